// ---- src/iwd_pkg.sv ----
// package for the instruction word decoder: field positions, opcodes, timing
// assumes a 14-bit program word and a four-phase instruction cycle
package iwd_pkg;

	// ----------------------------------------------------------------
	// word layout
	// ----------------------------------------------------------------
	localparam int IWD_WORD_W = 14;
	localparam int IWD_FILE_W = 7;
	localparam int IWD_BIT_W = 3;
	localparam int IWD_LIT8_W = 8;
	localparam int IWD_LIT11_W = 11;
	localparam int IWD_DEST_POS = 7;
	localparam int IWD_BITNUM_POS = 7;
	localparam int IWD_CLASS_MSB = 13;
	localparam int IWD_CLASS_LSB = 12;
	localparam int IWD_NIB_MSB = 11;
	localparam int IWD_NIB_LSB = 8;

	// ----------------------------------------------------------------
	// class codes in the top two bits
	// ----------------------------------------------------------------
	localparam logic [1:0] IWD_TOP_BYTE = 2'h0;
	localparam logic [1:0] IWD_TOP_BIT = 2'h1;
	localparam logic [1:0] IWD_TOP_JUMP = 2'h2;
	localparam logic [1:0] IWD_TOP_LIT = 2'h3;

	// ----------------------------------------------------------------
	// fixed control words
	// ----------------------------------------------------------------
	localparam logic [13:0] IWD_OP_STANDBY = 14'h0063;
	localparam logic [13:0] IWD_OP_WDT_CLEAR = 14'h0064;
	localparam logic [13:0] IWD_OP_RETURN = 14'h0008;
	localparam logic [13:0] IWD_OP_RETFIE = 14'h0009;
	localparam logic [3:0] IWD_NIB_INCFSZ = 4'hF;
	localparam logic [3:0] IWD_NIB_DECFSZ = 4'hB;
	localparam logic [3:0] IWD_NIB_RETLW = 4'h4;
	localparam logic [1:0] IWD_BITOP_TEST_CLR = 2'h2;
	localparam logic [1:0] IWD_BITOP_TEST_SET = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int IWD_PHASES = 4;
	localparam logic [1:0] IWD_PHASE_LAST = 2'(IWD_PHASES - 1);
	localparam logic [1:0] IWD_CYC_ONE = 2'h1;
	localparam logic [1:0] IWD_CYC_TWO = 2'h2;
	localparam logic IWD_FLAG_RESET = 1'h1;

	typedef enum logic [1:0] {IWD_CLS_BYTE, IWD_CLS_BIT, IWD_CLS_LITCTL} iwd_class_t;

endpackage : iwd_pkg

// ---- src/iwd_phase_seq.sv ----
// four-phase sequencer forming one instruction cycle from four clocks
// assumes clk_sys is the oscillator period; one clock equals one phase
`timescale 1ns/1ps
module iwd_phase_seq
	import iwd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	output logic [1:0] phase,
	output logic cycle_end
);

	// ----------------------------------------------------------------
	// phase counter
	// ----------------------------------------------------------------
	// free-running count; wraps after the last phase
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign cycle_end = (phase == IWD_PHASE_LAST);

endmodule : iwd_phase_seq

// ---- src/iwd_decoder.sv ----
// instruction word decoder: classes, operand fields, cycle count, status bits
// assumes the fetch path holds fetch_word stable and same-clock; the datapath
// reports branch_taken for the current word before the cycle's last phase
`timescale 1ns/1ps
module iwd_decoder
	import iwd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [13:0] fetch_word,
	input wire logic branch_taken,
	input wire logic watchdog_expired,
	output iwd_class_t op_class,
	output logic [6:0] file_addr,
	output logic dest_file,
	output logic dest_accum,
	output logic [2:0] bit_num,
	output logic [7:0] lit8,
	output logic [10:0] lit11,
	output logic lit_is_wide,
	output logic [1:0] cycle_count,
	output logic second_is_nop,
	output logic standby_op,
	output logic watchdog_clear_op,
	output logic cycle_start,
	output logic expiry_status_flag,
	output logic sleep_entered_flag
);

	// ----------------------------------------------------------------
	// phase sequencer
	// ----------------------------------------------------------------
	logic [1:0] phase;
	logic cycle_end;

	iwd_phase_seq u_seq (
		.clk_sys(clk_sys),
		.reset(reset),
		.phase(phase),
		.cycle_end(cycle_end)
	);

	// ----------------------------------------------------------------
	// field extraction
	// ----------------------------------------------------------------
	logic [1:0] top;
	logic [3:0] nib;
	logic is_byte;
	logic is_bit;
	logic [6:0] w_file;
	logic w_dest;
	logic [2:0] w_bit;
	logic [7:0] w_lit8;
	logic [10:0] w_lit11;
	logic w_wide;
	logic w_standby;
	logic w_wdt_clear;
	logic w_pc_change;
	logic w_cond;
	logic w_ctl_word;
	iwd_class_t next_class;

	// the word is sliced by position only, so don't-care bits never steer anything
	assign top = fetch_word[IWD_CLASS_MSB:IWD_CLASS_LSB];
	assign nib = fetch_word[IWD_NIB_MSB:IWD_NIB_LSB];
	// the fixed control words share the byte opcode space and must not look like byte ops
	assign is_byte = (top == IWD_TOP_BYTE) && !w_ctl_word;
	assign is_bit = (top == IWD_TOP_BIT);
	assign next_class = is_byte ? IWD_CLS_BYTE : (is_bit ? IWD_CLS_BIT : IWD_CLS_LITCTL);
	assign w_file = fetch_word[IWD_FILE_W-1:0];
	assign w_dest = fetch_word[IWD_DEST_POS];
	assign w_bit = fetch_word[IWD_BITNUM_POS+IWD_BIT_W-1:IWD_BITNUM_POS];
	assign w_lit8 = fetch_word[IWD_LIT8_W-1:0];
	assign w_lit11 = fetch_word[IWD_LIT11_W-1:0];
	assign w_wide = (top == IWD_TOP_JUMP);

	// ----------------------------------------------------------------
	// special words and cycle length
	// ----------------------------------------------------------------
	assign w_standby = (fetch_word == IWD_OP_STANDBY);
	assign w_wdt_clear = (fetch_word == IWD_OP_WDT_CLEAR);
	// control words are matched whole: standby, watchdog clear and both returns
	assign w_ctl_word = w_standby || w_wdt_clear
		|| (fetch_word == IWD_OP_RETURN)
		|| (fetch_word == IWD_OP_RETFIE);
	// call, goto, return, return-from-interrupt, literal return always branch
	assign w_pc_change = (top == IWD_TOP_JUMP)
		|| (fetch_word == IWD_OP_RETURN)
		|| (fetch_word == IWD_OP_RETFIE)
		|| ((top == IWD_TOP_LIT) && (nib[3:2] == IWD_NIB_RETLW[3:2]));
	// skip-type tests; writes to the program counter through a file register are not seen
	assign w_cond = (is_byte && ((nib == IWD_NIB_INCFSZ) || (nib == IWD_NIB_DECFSZ)))
		|| (is_bit && ((nib[3:2] == IWD_BITOP_TEST_CLR) || (nib[3:2] == IWD_BITOP_TEST_SET)));

	// ----------------------------------------------------------------
	// registered decode, loaded at the end of each cycle
	// ----------------------------------------------------------------
	logic in_second;
	logic next_second;
	logic two_cycle;
	logic [1:0] next_count;
	logic next_dest_file;
	logic next_dest_accum;
	logic next_standby;
	logic next_wdt_clear;

	// conditional ops go long only when the datapath says the test passed
	assign two_cycle = w_pc_change || (w_cond && branch_taken);
	// a long instruction's second cycle runs as a bubble and never marks another bubble after it
	assign next_second = two_cycle && !in_second;
	assign next_count = two_cycle ? IWD_CYC_TWO : IWD_CYC_ONE;
	// strobes are masked in a bubble so the datapath never acts on a word twice
	assign next_dest_file = is_byte && w_dest && !in_second;
	assign next_dest_accum = is_byte && !w_dest && !in_second;
	assign next_standby = w_standby && !in_second;
	assign next_wdt_clear = w_wdt_clear && !in_second;

	// bubble tracking and cycle length
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			in_second <= 1'h0;
			second_is_nop <= 1'h0;
			cycle_count <= IWD_CYC_ONE;
		end else if (cycle_end) begin
			in_second <= next_second;
			second_is_nop <= in_second;
			cycle_count <= next_count;
		end
	end

	// operand fields change only at a cycle boundary, so they stand for four phases
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			op_class <= IWD_CLS_BYTE;
			file_addr <= 7'h00;
			bit_num <= 3'h0;
			lit8 <= 8'h00;
			lit11 <= 11'h000;
			lit_is_wide <= 1'h0;
		end else if (cycle_end) begin
			op_class <= next_class;
			file_addr <= w_file;
			bit_num <= w_bit;
			lit8 <= w_lit8;
			lit11 <= w_lit11;
			lit_is_wide <= w_wide;
		end
	end

	// execution strobes; all of them read zero in a bubble cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dest_file <= 1'h0;
			dest_accum <= 1'h0;
			standby_op <= 1'h0;
			watchdog_clear_op <= 1'h0;
		end else if (cycle_end) begin
			dest_file <= next_dest_file;
			dest_accum <= next_dest_accum;
			standby_op <= next_standby;
			watchdog_clear_op <= next_wdt_clear;
		end
	end

	// marks the first phase of each instruction cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cycle_start <= 1'h0;
		end else begin
			cycle_start <= cycle_end;
		end
	end

	// ----------------------------------------------------------------
	// status bits, active low in meaning: 1 = no event
	// ----------------------------------------------------------------
	logic wd_meta;
	logic wd_sync;
	logic exec_tick;
	logic set_expiry;
	logic enter_sleep;
	logic leave_sleep;

	// watchdog time-out comes from another timer domain: two flops first
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wd_meta <= 1'h0;
			wd_sync <= 1'h0;
		end else begin
			wd_meta <= watchdog_expired;
			wd_sync <= wd_meta;
		end
	end

	// standby and watchdog clear updates land on the first phase of the executing cycle; a time-out lands on any phase once wd_sync is high
	assign exec_tick = cycle_start;
	// the strobes stand four phases; qualifying with the tick makes each act once
	assign set_expiry = exec_tick && (standby_op || watchdog_clear_op);
	assign enter_sleep = exec_tick && standby_op;
	assign leave_sleep = exec_tick && watchdog_clear_op;

	// expiry: set by standby or watchdog clear, cleared by a time-out;
	// the time-out wins, since losing it would hide a real expiry
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			expiry_status_flag <= IWD_FLAG_RESET;
		end else if (wd_sync) begin
			expiry_status_flag <= 1'h0;
		end else if (set_expiry) begin
			expiry_status_flag <= 1'h1;
		end
	end

	// sleep entry: cleared by standby, set again by a watchdog clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sleep_entered_flag <= IWD_FLAG_RESET;
		end else if (enter_sleep) begin
			sleep_entered_flag <= 1'h0;
		end else if (leave_sleep) begin
			sleep_entered_flag <= 1'h1;
		end
	end

endmodule : iwd_decoder

// ---- sim/iwd_decoder_checker.sv ----
// port-timing checker for the instruction word decoder
// assumes it is bound into iwd_decoder and sees its ports only
`timescale 1ns/1ps
module iwd_decoder_checker
	import iwd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input iwd_class_t op_class,
	input wire logic dest_file,
	input wire logic dest_accum,
	input wire logic [6:0] file_addr,
	input wire logic [1:0] cycle_count,
	input wire logic second_is_nop,
	input wire logic standby_op,
	input wire logic watchdog_clear_op,
	input wire logic cycle_start,
	input wire logic sleep_entered_flag
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// cycle start marks every fourth clock, never sooner
	start_period_a: assert property (cycle_start |-> ##4 cycle_start)
		else $error("cycle start period wrong");
	start_gap_a: assert property (cycle_start |=> !cycle_start [*3])
		else $error("cycle start too early");
	// destinations only for byte words outside a bubble
	dest_byte_a: assert property ((dest_file || dest_accum) |->
		op_class == IWD_CLS_BYTE && !second_is_nop && !(dest_file && dest_accum))
		else $error("destination outside byte class");
	// fields may only move together with the cycle start pulse
	hold_fields_a: assert property (!cycle_start |->
		$stable(file_addr) && $stable(op_class) && $stable(cycle_count))
		else $error("decode output moved mid cycle");
	bubble_after_a: assert property (cycle_start && cycle_count == IWD_CYC_TWO &&
		!second_is_nop |-> ##4 second_is_nop)
		else $error("two-cycle word without bubble");
	nop_quiet_a: assert property (second_is_nop |-> !standby_op && !watchdog_clear_op)
		else $error("bubble cycle carries an operation");
	sleep_flag_a: assert property (cycle_start && standby_op |=> !sleep_entered_flag)
		else $error("standby left sleep flag set");
	clear_flag_a: assert property (cycle_start && watchdog_clear_op |=> sleep_entered_flag)
		else $error("watchdog clear left sleep flag low");
	flag_hold_a: assert property (!$past(cycle_start) |-> $stable(sleep_entered_flag))
		else $error("sleep flag moved off its slot");
endmodule : iwd_decoder_checker

bind iwd_decoder iwd_decoder_checker iwd_decoder_checker_inst(.clk_sys(clk_sys),
	.reset(reset), .op_class(op_class), .dest_file(dest_file), .dest_accum(dest_accum),
	.file_addr(file_addr), .cycle_count(cycle_count), .second_is_nop(second_is_nop),
	.standby_op(standby_op), .watchdog_clear_op(watchdog_clear_op),
	.cycle_start(cycle_start), .sleep_entered_flag(sleep_entered_flag));

// ---- sim/iwd_fetch_model.sv ----
// fetch path model: presents one program word and the branch verdict
// assumes requests change at the falling edge
`timescale 1ns/1ps
module iwd_fetch_model
	import iwd_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [13:0] req_word,
	input wire logic req_branch,
	output logic [13:0] fetch_word,
	output logic branch_taken
);
	// ----------------------------------------------------------------
	// launch
	// ----------------------------------------------------------------
	// launched just after a rising edge so the word is settled by phase 3
	always_ff @(posedge clk_sys) begin
		fetch_word <= req_word;
		branch_taken <= req_branch;
	end
endmodule : iwd_fetch_model

// ---- sim/instruction_word_decoder_tb_top.sv ----
// self-checking bench for the instruction word decoder
// assumes the fetch model feeds words and the checker is bound in
`timescale 1ns/1ps
module instruction_word_decoder_tb_top import iwd_pkg::*;;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic watchdog_expired = 1'b0;
	logic req_branch = 1'b0;
	logic bub = 1'b0;
	logic [13:0] req_word = 14'h0000;
	logic [13:0] fetch_word;
	iwd_class_t op_class;
	logic [6:0] file_addr;
	logic [2:0] bit_num;
	logic [7:0] lit8;
	logic [10:0] lit11;
	logic [1:0] cycle_count;
	logic branch_taken, dest_file, dest_accum, lit_is_wide, second_is_nop, standby_op;
	logic watchdog_clear_op, cycle_start, expiry_status_flag, sleep_entered_flag;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	// ----------------------------------------------------------------
	// clock, parts, timeout
	// ----------------------------------------------------------------
	always #12.5 clk_sys = ~clk_sys;
	iwd_fetch_model iwd_fetch_model_inst(.clk_sys(clk_sys), .req_word(req_word),
		.req_branch(req_branch), .fetch_word(fetch_word), .branch_taken(branch_taken));
	iwd_decoder iwd_decoder_inst(.clk_sys(clk_sys), .reset(reset), .fetch_word(fetch_word),
		.branch_taken(branch_taken), .watchdog_expired(watchdog_expired),
		.op_class(op_class), .file_addr(file_addr), .dest_file(dest_file),
		.dest_accum(dest_accum), .bit_num(bit_num), .lit8(lit8), .lit11(lit11),
		.lit_is_wide(lit_is_wide), .cycle_count(cycle_count), .second_is_nop(second_is_nop),
		.standby_op(standby_op), .watchdog_clear_op(watchdog_clear_op),
		.cycle_start(cycle_start), .expiry_status_flag(expiry_status_flag),
		.sleep_entered_flag(sleep_entered_flag));
	// a hang would otherwise never reach the report
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one word per instruction cycle, judged at the following cycle start
	task automatic apply(input logic [13:0] w, input logic br);
		logic two, nop, ctl, byt;
		nop = bub;
		ctl = w == 14'h0008 || w == 14'h0009 || w == 14'h0063 || w == 14'h0064;
		byt = w[13:12] == 2'h0 && !ctl;
		two = w[13:12] == 2'h2 || w[13:1] == 13'h0004 || w[13:10] == 4'hD
			|| (br && (w[13:8] == 6'h0F || w[13:8] == 6'h0B || w[13:11] == 3'h3));
		req_word = w;
		req_branch = br;
		repeat (4) @(negedge clk_sys);
		chk(cycle_start, 1'b1);
		chk(op_class, byt ? 2'h0 : (w[13:12] == 2'h1 ? 2'h1 : 2'h2));
		chk(file_addr, w[6:0]);
		chk(bit_num, w[9:7]);
		chk(lit8, w[7:0]);
		chk(lit11, w[10:0]);
		chk(lit_is_wide, w[13:12] == 2'h2);
		chk(dest_file, byt && w[7] && !nop);
		chk(dest_accum, byt && !w[7] && !nop);
		chk(cycle_count, two ? 2'h2 : 2'h1);
		chk(second_is_nop, nop);
		chk(standby_op, w == 14'h0063 && !nop);
		chk(watchdog_clear_op, w == 14'h0064 && !nop);
		bub = two && !nop;
	endtask : apply
	task automatic t_byte();
		apply(14'h0780, 1'b0);
		apply(14'h077F, 1'b0);
		apply(14'h0100, 1'b0);
		apply(14'h017F, 1'b0);
		$display("byte test done");
	endtask : t_byte
	task automatic t_bit();
		for (int b = 0; b < 8; b++) begin
			apply({4'h5, 3'(b), 7'h2A}, 1'b0);
		end
		apply(14'h1800, 1'b1);
		apply(14'h0F80, 1'b1);
		apply(14'h0B00, 1'b1);
		apply(14'h1C00, 1'b0);
		$display("bit test done");
	endtask : t_bit
	task automatic t_lit();
		apply(14'h30A5, 1'b0);
		apply(14'h2FFF, 1'b0);
		apply(14'h30A5, 1'b0);
		apply(14'h2000, 1'b0);
		apply(14'h3E55, 1'b0);
		apply(14'h3F55, 1'b0);
		apply(14'h3400, 1'b0);
		apply(14'h37FF, 1'b0);
		apply(14'h0008, 1'b0);
		apply(14'h0009, 1'b0);
		$display("literal test done");
	endtask : t_lit
	task automatic t_status();
		watchdog_expired = 1'b1;
		apply(14'h30A5, 1'b0);
		watchdog_expired = 1'b0;
		apply(14'h30A5, 1'b0);
		chk(expiry_status_flag, 1'b0);
		apply(14'h0063, 1'b0);
		apply(14'h30A5, 1'b0);
		chk(sleep_entered_flag, 1'b0);
		chk(expiry_status_flag, 1'b1);
		watchdog_expired = 1'b1;
		apply(14'h30A5, 1'b0);
		watchdog_expired = 1'b0;
		chk(expiry_status_flag, 1'b0);
		apply(14'h0064, 1'b0);
		apply(14'h30A5, 1'b0);
		chk(sleep_entered_flag, 1'b1);
		chk(expiry_status_flag, 1'b1);
		$display("status test done");
	endtask : t_status
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (12) @(negedge clk_sys);
		reset = 1'b0;
		chk(cycle_count, 2'h1);
		chk(expiry_status_flag, 1'b1);
		while (cycle_start !== 1'b1) @(negedge clk_sys);
		t_byte();
		t_bit();
		t_lit();
		t_status();
		complete_run();
	end
endmodule : instruction_word_decoder_tb_top
